// File: design/serial_rx_pkg.sv
// constants and carriers for the serial receiver word output and link status block
// assumes a decoder upstream that splits each received word into code field, payload and flag
package serial_rx_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATE  = 8'h04;
  localparam logic [7:0] REG_IRQ    = 8'h08;
  localparam logic [7:0] REG_MASK   = 8'h0c;
  localparam logic [7:0] REG_WORD   = 8'h10;

  // ---------------------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------------------
  localparam int         CTRL_W          = 3;
  localparam int         CTRL_FLAG_EN    = 0;
  localparam int         CTRL_ESMPX      = 1;
  localparam int         CTRL_LOCAL_SYNC = 2;
  localparam logic [2:0] CTRL_RST        = 3'h2;

  // ---------------------------------------------------------------------------
  // interrupt status / mask bits
  // ---------------------------------------------------------------------------
  localparam int         IRQ_W      = 4;
  localparam int         IRQ_ERR    = 0;
  localparam int         IRQ_UP     = 1;
  localparam int         IRQ_DOWN   = 2;
  localparam int         IRQ_SLIP   = 3;
  localparam logic [3:0] MASK_RST   = 4'h0;

  // ---------------------------------------------------------------------------
  // link qualification
  // ---------------------------------------------------------------------------
  localparam int         WORD_W      = 16;
  localparam int         CWORD_W     = 14;
  localparam logic [7:0] READY_RUN   = 8'h40;
  localparam logic [1:0] ERR_LIMIT   = 2'h2;

  // code field patterns, both polarities of the conditional inversion
  localparam logic [3:0] CODE_DATA_P = 4'h5;
  localparam logic [3:0] CODE_DATA_N = 4'ha;
  localparam logic [3:0] CODE_CTRL_P = 4'h3;
  localparam logic [3:0] CODE_CTRL_N = 4'hc;
  localparam logic [3:0] CODE_IDLE_P = 4'h6;
  localparam logic [3:0] CODE_IDLE_N = 4'h9;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]        code;
    logic [WORD_W-1:0] payload;
    logic              flag;
  } rxWord_t;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic              flag;
    logic              dataValid;
    logic              ctrlValid;
    logic              error;
    logic              ready;
  } rxOut_t;

endpackage

// File: design/serial_rx_word_output_status.sv
// receiver word output and link status, with an apb register slave and interrupt
// assumes decodedWord changes on the falling edge of recoveredWordClock and is
// stable at its rising edge; both link clocks are far slower than clk
//
// Summary of operation
// - flag enable presents flag as seventeenth bit
// - enhanced mode descrambles the flag bit
// - local sync times outputs by reference clock
// - local sync flags word slips against reference edge
// - data valid marks data word outputs
// - control valid marks fourteen-bit control word
// - flag carries transmitted flag when enabled
// - ready after 64 error-free consecutive words
// - enhanced mode also checks flag toggling when flag enable is off
// - ready drops on two errors or toggle miss
// - error flags words of no valid encoding
// - local sync launches word and status outputs on reference
// - else launch on falling edge, inverse clock
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps

module serial_rx_word_output_status
  import serial_rx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              recoveredWordClock,
  input  wire logic              localReferenceClock,
  input  wire rxWord_t           decodedWord,
  output logic      [WORD_W-1:0] rxWord,
  output logic                   flagBitOut,
  output logic                   dataWordValid,
  output logic                   controlWordValid,
  output logic                   linkReady,
  output logic                   wordError,
  output logic                   wordSlipOut,
  output logic                   recoveredWordClockOut,
  output logic                   recoveredWordClockInverted,
  output logic                   irq
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  // one record for every flop keeps the reset and the register step in one place
  typedef struct packed {
    logic              recSync1;
    logic              recSync2;
    logic              recPrev;
    logic              refSync1;
    logic              refSync2;
    logic              refPrev;
    rxWord_t           wordSync1;
    rxWord_t           wordSync2;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0]  irqStatus;
    logic [IRQ_W-1:0]  irqMask;
    rxOut_t            hold;
    rxOut_t            out;
    logic              slip;
    logic [1:0]        pend;
    logic              ready;
    logic [7:0]        runCount;
    logic [1:0]        errRun;
    logic              lastFlag;
    logic              seenData;
    logic              scramble;
    logic              clkOut;
    logic              clkInv;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
  } state_t;

  state_t state;
  state_t next_state;

  // ---------------------------------------------------------------------------
  // decode signals
  // ---------------------------------------------------------------------------
  logic              recRise;
  logic              recFall;
  logic              refRise;
  logic              flagEn;
  logic              esmpx;
  logic              localSync;
  logic              isData;
  logic              isCtrl;
  logic              isIdle;
  logic              invalid;
  logic              descFlag;
  logic              toggleMiss;
  logic              launch;
  logic              phaseOff;
  logic [IRQ_W-1:0]  events;
  logic              apbAccess;
  logic              apbDone;
  logic [1:0]        errNext;

  always_comb
  begin
    next_state = state;
    events     = '0;
    phaseOff   = 1'b0;

    // -------------------------------------------------------------------------
    // link side sampling
    // -------------------------------------------------------------------------
    // data words take the same two stages as the clock, so they stay aligned
    next_state.recSync1  = recoveredWordClock;
    next_state.recSync2  = state.recSync1;
    next_state.recPrev   = state.recSync2;
    next_state.refSync1  = localReferenceClock;
    next_state.refSync2  = state.refSync1;
    next_state.refPrev   = state.refSync2;
    next_state.wordSync1 = decodedWord;
    next_state.wordSync2 = state.wordSync1;
    recRise = state.recSync2 & ~state.recPrev;
    recFall = ~state.recSync2 & state.recPrev;
    refRise = state.refSync2 & ~state.refPrev;

    flagEn    = state.ctrl[CTRL_FLAG_EN];
    esmpx     = state.ctrl[CTRL_ESMPX];
    localSync = state.ctrl[CTRL_LOCAL_SYNC];

    // -------------------------------------------------------------------------
    // word classification
    // -------------------------------------------------------------------------
    isData  = (state.wordSync2.code == CODE_DATA_P) || (state.wordSync2.code == CODE_DATA_N);
    isCtrl  = (state.wordSync2.code == CODE_CTRL_P) || (state.wordSync2.code == CODE_CTRL_N);
    isIdle  = (state.wordSync2.code == CODE_IDLE_P) || (state.wordSync2.code == CODE_IDLE_N);
    invalid = ~(isData | isCtrl | isIdle);

    // scrambling key alternates per data word; the far end must run the same mode
    descFlag = esmpx ? (state.wordSync2.flag ^ state.scramble) : state.wordSync2.flag;
    // an unused flag must alternate, so a repeat means lost alignment; the first
    // data word after reset has nothing to compare with and is never a miss
    toggleMiss = esmpx & ~flagEn & isData & state.seenData
               & (descFlag == state.lastFlag);
    errNext = (state.errRun == ERR_LIMIT) ? ERR_LIMIT : state.errRun + 2'h1;

    // -------------------------------------------------------------------------
    // capture on recovered rising edge
    // -------------------------------------------------------------------------
    if (recRise)
    begin
      next_state.hold.dataValid = isData;
      next_state.hold.ctrlValid = isCtrl;
      next_state.hold.error     = invalid;
      if (isData)
        next_state.hold.word = state.wordSync2.payload;
      else if (isCtrl)
        next_state.hold.word = {2'h0, state.wordSync2.payload[CWORD_W-1:0]};
      else
        next_state.hold.word = '0;
      // control words carry no flag
      next_state.hold.flag = flagEn & isData & descFlag;
      if (isData)
      begin
        next_state.lastFlag = descFlag;
        next_state.seenData = 1'b1;
        next_state.scramble = ~state.scramble;
      end
      // a single bad word only restarts the run; two in a row drop ready
      if (invalid)
      begin
        next_state.errRun   = errNext;
        next_state.runCount = '0;
        if (errNext == ERR_LIMIT)
          next_state.ready = 1'b0;
      end
      else if (toggleMiss)
      begin
        next_state.errRun   = '0;
        next_state.runCount = '0;
        next_state.ready    = 1'b0;
      end
      else
      begin
        next_state.errRun = '0;
        if (state.runCount != READY_RUN)
          next_state.runCount = state.runCount + 8'h1;
        if (state.runCount + 8'h1 >= READY_RUN)
          next_state.ready = 1'b1;
      end
      next_state.hold.ready = next_state.ready;
      events[IRQ_ERR]  = invalid;
      events[IRQ_UP]   = next_state.ready & ~state.ready;
      events[IRQ_DOWN] = ~next_state.ready & state.ready;
    end

    // -------------------------------------------------------------------------
    // launch: reference rising edge, or recovered falling edge
    // -------------------------------------------------------------------------
    // outputs hold between launches so the reader always sees a steady word
    launch = localSync ? refRise : recFall;
    if (launch)
    begin
      next_state.out = state.hold;
      // exactly one capture per reference period keeps the word in phase; a second
      // capture, a missing one or one that lands on the launch cycle means a
      // word was skipped or shown twice
      phaseOff        = (state.pend != 2'h1) || recRise;
      next_state.slip = localSync & state.ready & phaseOff;
      next_state.pend = recRise ? 2'h1 : 2'h0;
      events[IRQ_SLIP] = next_state.slip;
    end
    else if (recRise && state.pend != 2'h3)
      next_state.pend = state.pend + 2'h1;

    next_state.clkOut = state.recSync2;
    next_state.clkInv = ~state.recSync2;

    // -------------------------------------------------------------------------
    // apb slave, one wait state
    // -------------------------------------------------------------------------
    apbAccess = psel & penable & ~state.pready;
    apbDone   = psel & penable & state.pready;
    next_state.pready  = apbAccess;
    // the error answer stands only beside its pready
    next_state.pslverr = 1'b0;
    // prdata keeps its last answer, which the read-clear below relies on
    if (apbAccess)
    begin
      next_state.prdata  = '0;
      if (paddr == REG_CTRL)
        next_state.prdata[CTRL_W-1:0] = state.ctrl;
      else if (paddr == REG_STATE)
        next_state.prdata[7:0] = {state.runCount[6:0], state.ready};
      else if (paddr == REG_IRQ)
        next_state.prdata[IRQ_W-1:0] = state.irqStatus;
      else if (paddr == REG_MASK)
        next_state.prdata[IRQ_W-1:0] = state.irqMask;
      else if (paddr == REG_WORD)
        next_state.prdata[WORD_W+1:0] = {state.out.flag, state.out.dataValid, state.out.word};
      else
        next_state.pslverr = 1'b1;
    end
    if (apbDone && pwrite)
    begin
      if (paddr == REG_CTRL)
        next_state.ctrl = pwdata[CTRL_W-1:0];
      else if (paddr == REG_MASK)
        next_state.irqMask = pwdata[IRQ_W-1:0];
    end

    // -------------------------------------------------------------------------
    // interrupts
    // -------------------------------------------------------------------------
    // only bits already reported are cleared; new events win
    if (apbDone && !pwrite && paddr == REG_IRQ)
      next_state.irqStatus = state.irqStatus & ~state.prdata[IRQ_W-1:0];
    next_state.irqStatus = next_state.irqStatus | events;
    next_state.irq       = |(next_state.irqStatus & next_state.irqMask);
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  // control comes up with enhanced mode on, so a matching far end qualifies at once
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state         <= '0;
      state.ctrl    <= CTRL_RST;
      state.irqMask <= MASK_RST;
    end
    else
      state <= next_state;
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign prdata                     = state.prdata;
  assign pready                     = state.pready;
  assign pslverr                    = state.pslverr;
  assign rxWord                     = state.out.word;
  assign flagBitOut                 = state.out.flag;
  assign dataWordValid              = state.out.dataValid;
  assign controlWordValid           = state.out.ctrlValid;
  assign linkReady                  = state.out.ready;
  assign wordError                  = state.out.error;
  assign wordSlipOut                = state.slip;
  assign recoveredWordClockOut      = state.clkOut;
  assign recoveredWordClockInverted = state.clkInv;
  assign irq                        = state.irq;

endmodule

// File: sim/link_tx_model.sv
// transmitter model: free running word clock and decoded words, idles between
// assumes the bench pushes words into q; one word per clock period
`timescale 1ns/100ps

module link_tx_model
  import serial_rx_pkg::*;
(
  input  wire logic txFlagBitEnable,
  input  wire logic enhancedEnable,
  output logic      recoveredWordClock,
  output rxWord_t   decodedWord
);
  rxWord_t q[$];
  rxWord_t w;
  logic    key = 1'b0;
  logic    alt = 1'b0;
  logic    f;

  // ---------------------------------------------------------------------------
  // word stream
  // ---------------------------------------------------------------------------
  initial
  begin
    recoveredWordClock = 1'b0;
    decodedWord = {CODE_IDLE_P, 16'h0000, 1'b0};
    #7;
    forever #80 recoveredWordClock = ~recoveredWordClock;
  end

  always @(negedge recoveredWordClock)
  begin
    w = {CODE_IDLE_P, 16'h0000, 1'b0};
    if (q.size() != 0)
      w = q.pop_front();
    if (w.code == CODE_DATA_P || w.code == CODE_DATA_N)
    begin
      f = txFlagBitEnable ? w.flag : alt;
      alt = ~alt;
      w.flag = enhancedEnable ? f ^ key : f;
      key = ~key;
    end
    else
      w.flag = ~decodedWord.flag;
    decodedWord <= w;
  end
endmodule

// File: sim/serial_rx_sva.sv
// checker for the receiver word outputs, recovered clock copies and apb answer
// assumes it is bound onto serial_rx_word_output_status
`timescale 1ns/100ps

module serial_rx_checker
  import serial_rx_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              recoveredWordClock,
  input wire logic [WORD_W-1:0] rxWord,
  input wire logic              flagBitOut,
  input wire logic              dataWordValid,
  input wire logic              controlWordValid,
  input wire logic              linkReady,
  input wire logic              wordError,
  input wire logic              recoveredWordClockOut,
  input wire logic              recoveredWordClockInverted
);
  logic [2:0] upCnt;

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  // past values reach back into reset for three edges after release
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      upCnt <= 3'h0;
    else if (upCnt != 3'h4)
      upCnt <= upCnt + 3'h1;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_excl; !(dataWordValid && controlWordValid); endproperty
  a_excl: assert property (p_excl) else $error("both valid qualifiers high");
  property p_ctrl; controlWordValid |-> rxWord[15:14] == 2'h0; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control word top bits set");
  property p_flag; flagBitOut |-> dataWordValid; endproperty
  a_flag: assert property (p_flag) else $error("flag without data word");
  property p_err; wordError |-> !dataWordValid && !controlWordValid; endproperty
  a_err: assert property (p_err) else $error("error word marked valid");
  property p_idle; !dataWordValid && !controlWordValid |-> rxWord == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("idle word not zero");
  property p_copy; upCnt == 3'h4 |-> recoveredWordClockOut == $past(recoveredWordClock, 3);
  endproperty
  a_copy: assert property (p_copy) else $error("clock copy delay wrong");
  property p_inv; upCnt == 3'h4 |-> recoveredWordClockInverted == !recoveredWordClockOut;
  endproperty
  a_inv: assert property (p_inv) else $error("clock not inverse");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("apb answer late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_slverr; pslverr |-> pready && prdata == 32'h0; endproperty
  a_slverr: assert property (p_slverr) else $error("bad error answer");

  c_up: cover property ($rose(linkReady));
  c_down: cover property ($fell(linkReady));
  c_ctrl: cover property (controlWordValid);
  c_err: cover property (wordError);
endmodule

bind serial_rx_word_output_status serial_rx_checker serial_rx_checker_inst (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .recoveredWordClock(recoveredWordClock),
  .rxWord(rxWord), .flagBitOut(flagBitOut), .dataWordValid(dataWordValid),
  .controlWordValid(controlWordValid), .linkReady(linkReady), .wordError(wordError),
  .recoveredWordClockOut(recoveredWordClockOut),
  .recoveredWordClockInverted(recoveredWordClockInverted));

// File: sim/tb.sv
// bench: apb register access and word stream scenarios with expected values
// assumes link_tx_model on the link side and the bound checker
`timescale 1ns/100ps

module tb
  import serial_rx_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        local_reference_clock = 1'b0;
  logic        txFlagEn = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, recClk, flagBitOut, dataWordValid, controlWordValid;
  logic        linkReady, wordError, irq, wordSlipOut;
  logic [15:0] rxWord;
  rxWord_t     dw;
  int          nFail = 0;
  int          totalChecks = 0;
  logic [41:0] tbl [5] = '{{CODE_CTRL_N, 16'hffff, 1'b0, 16'h3fff, 5'b00101},
    {CODE_DATA_N, 16'h1234, 1'b1, 16'h1234, 5'b11001},
    {CODE_DATA_P, 16'h4321, 1'b1, 16'h4321, 5'b11001},
    {CODE_DATA_P, 16'h8000, 1'b0, 16'h8000, 5'b01001},
    {CODE_IDLE_N, 16'hbeef, 1'b1, 16'h0000, 5'b00001}};

  always #10 clk = ~clk;
  initial
  begin
    #47;
    forever #80 local_reference_clock = ~local_reference_clock;
  end

  serial_rx_word_output_status serial_rx_word_output_status_inst (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .recoveredWordClock(recClk), .localReferenceClock(local_reference_clock), .decodedWord(dw),
    .rxWord(rxWord), .flagBitOut(flagBitOut), .dataWordValid(dataWordValid),
    .controlWordValid(controlWordValid), .linkReady(linkReady), .wordError(wordError),
    .wordSlipOut(wordSlipOut), .recoveredWordClockOut(), .recoveredWordClockInverted(), .irq(irq));
  link_tx_model link_tx_model_inst (.txFlagBitEnable(txFlagEn), .enhancedEnable(1'b1),
    .recoveredWordClock(recClk), .decodedWord(dw));

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nFail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // waits until the last queued word is launched; holds until the next launch
  task automatic settle();
    while (link_tx_model_inst.q.size() != 0)
      @(posedge clk);
    @(negedge recClk);
    repeat (7) @(posedge clk);
  endtask
  task automatic send(input logic [3:0] c, input logic [15:0] p, input logic f);
    link_tx_model_inst.q.push_back({c, p, f});
  endtask
  // status bits: flag, data valid, control valid, error, ready
  task automatic outs(input logic [15:0] w, input logic [4:0] s);
    check({11'h0, rxWord, flagBitOut, dataWordValid, controlWordValid, wordError, linkReady},
      {11'h0, w, s});
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, {29'h0, CTRL_RST});
    apb(1'b0, REG_MASK, 32'h0);
    check(rd, {28'h0, MASK_RST});
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1);
    repeat (55) @(negedge recClk);
    outs(16'h0000, 5'b00000);
    repeat (12) @(negedge recClk);
    outs(16'h0000, 5'b00001);
    apb(1'b0, REG_STATE, 32'h0);
    check(rd, {24'h0, READY_RUN[6:0], 1'b1});
    apb(1'b0, REG_IRQ, 32'h0);
    check(rd, 32'h2);
    check({31'h0, irq}, 32'h0);
    send(CODE_DATA_P, 16'ha5c3, 1'b1);
    settle();
    outs(16'ha5c3, 5'b01001);
    apb(1'b0, REG_WORD, 32'h0);
    check(rd, 32'h0001a5c3);
    $display("ready test done");
    apb(1'b1, REG_MASK, 32'h1);
    send(4'h0, 16'h1111, 1'b0);
    settle();
    outs(16'h0000, 5'b00011);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, REG_IRQ, 32'h0);
    check(rd, 32'h1);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    send(4'hf, 16'h2222, 1'b0);
    send(4'h0, 16'h3333, 1'b0);
    settle();
    outs(16'h0000, 5'b00010);
    apb(1'b0, REG_IRQ, 32'h0);
    check(rd, 32'h5);
    $display("error test done");
    repeat (70) @(negedge recClk);
    apb(1'b1, REG_CTRL, 32'h3);
    txFlagEn <= 1'b1;
    foreach (tbl[i])
    begin
      send(tbl[i][41:38], tbl[i][37:22], tbl[i][21]);
      settle();
      outs(tbl[i][20:5], tbl[i][4:0]);
    end
    apb(1'b1, REG_CTRL, 32'h2);
    send(CODE_DATA_N, 16'h5555, 1'b0);
    settle();
    outs(16'h5555, 5'b01000);
    $display("word test done");
    apb(1'b1, REG_CTRL, 32'h6);
    repeat (70) @(negedge recClk);
    send(CODE_DATA_P, 16'h0f0f, 1'b1);
    settle();
    outs(16'h0f0f, 5'b01001);
    check({31'h0, wordSlipOut}, 32'h0);
    $display("local sync test done");
    giveVerdict();
  end

  initial
  begin
    #200000;
    nFail++;
    giveVerdict();
  end
endmodule
